// ==== design/tmc_pkg.sv ====
`default_nettype none
package tmc_pkg;
    // -------------------------------------------------------------
    // widths
    // -------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int NCHAN  = 2;

    // -------------------------------------------------------------
    // register offsets (byte addresses)
    // -------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_MODE_CTL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CHAN_EN  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CV2      = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CV3      = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h10;

    // -------------------------------------------------------------
    // mode control fields, one byte per channel (chan2 low byte)
    // -------------------------------------------------------------
    localparam int CHAN_FIELD_W = 8;
    localparam int MS_LSB       = 0;
    localparam int FAST_BIT     = 2;
    localparam int SHADOW_BIT   = 3;
    localparam int CTL_LSB      = 4;
    localparam int CLR_BIT      = 7;

    // enable/polarity fields: chan2 at 8/9, chan3 at 12/13
    localparam int EN_BIT_BASE  = 8;
    localparam int EN_STRIDE    = 4;
    localparam int POL_OFS      = 1;

    // status fields
    localparam int ST_PREP_LSB  = 0;
    localparam int ST_OUT_LSB   = 2;
    localparam int ST_SRC_LSB   = 4;

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [15:0]      MODE_CTL_RST = 16'h0000;
    localparam logic [15:0]      CHAN_EN_RST  = 16'h0000;
    localparam logic [CNT_W-1:0] CV_RST       = 16'h0000;

    // -------------------------------------------------------------
    // encodings
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        CMP_FROZEN     = 3'h0,
        CMP_SET        = 3'h1,
        CMP_CLEAR      = 3'h2,
        CMP_TOGGLE     = 3'h3,
        CMP_FORCE_LOW  = 3'h4,
        CMP_FORCE_HIGH = 3'h5,
        CMP_PWM0       = 3'h6,
        CMP_PWM1       = 3'h7
    } tmc_cmp_mode_t;

    typedef enum logic [1:0] {
        MS_OUTPUT   = 2'h0,
        MS_IN_OWN   = 2'h1,
        MS_IN_OTHER = 2'h2,
        MS_IN_TRIG  = 2'h3
    } tmc_ms_t;
endpackage : tmc_pkg
`default_nettype wire

// ==== design/tmc_cv_shadow.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmc_cv_shadow
#(
    parameter int W = 16
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         shadow_en,
    input  wire logic         update_event,
    output logic      [W-1:0] preload,
    output logic      [W-1:0] active
);
    import tmc_pkg::*;

    logic [W-1:0] preload_reg;
    logic [W-1:0] active_reg;

    // software copy, written from the bus
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            preload_reg <= W'(CV_RST);
        else if (wr_en)
            preload_reg <= wr_data;
    end

    // active copy: direct, or loaded only at update events
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            active_reg <= W'(CV_RST);
        else if (wr_en && !shadow_en)
            active_reg <= wr_data;
        else if (update_event)
            active_reg <= preload_reg;
    end

    assign preload = preload_reg;
    assign active  = active_reg;
endmodule : tmc_cv_shadow
`default_nettype wire

// ==== design/tmc_in_mux.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmc_in_mux
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] mode_select,
    input  wire logic       own_in,
    input  wire logic       other_in,
    input  wire logic       trig_in,
    output logic            input_source
);
    import tmc_pkg::*;

    logic src_reg;

    // picks the capture source; output mode drives low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            src_reg <= 1'b0;
        else
            unique case (tmc_ms_t'(mode_select))
                MS_OUTPUT:   src_reg <= 1'b0;
                MS_IN_OWN:   src_reg <= own_in;
                MS_IN_OTHER: src_reg <= other_in;
                MS_IN_TRIG:  src_reg <= trig_in;
            endcase
    end

    assign input_source = src_reg;
endmodule : tmc_in_mux
`default_nettype wire

// ==== design/tmc_top.sv ====
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - mode select field is write-protected while the channel enable bit is set
// - chan3 mode 00 output, 01 own input, 10 chan2 input, 11 trigger
// - chan2 mode 00 output, 01 own input, 10 chan3 input, 11 trigger
// - clear enable forces prepare low while filtered external trigger is high
// - frozen setting keeps prepare unchanged whatever the comparison says
// - setting 001 drives prepare high on match, 010 drives it low
// - setting 011 inverts prepare at each match
// - setting 100 forces prepare low, 101 forces it high
// - PWM0: high below compare counting up, low above compare counting down
// - PWM1: inverse of PWM0 in both directions
// - PWM prepare moves only on entry from frozen, a counter tick, a fast trigger edge or an external clear
// - shadow enable loads compare value into active copy only at update
// - fast enable in PWM makes a trigger edge act as a compare match
// - prepare high is active; polarity bits shape the channel output
// - chan3 has its own clear, control, shadow and fast fields at 15:10
module tmc_top
(
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // apb slave
    input  wire logic [tmc_pkg::ADDR_W-1:0]   paddr,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [tmc_pkg::DATA_W-1:0]   pwdata,
    output logic      [tmc_pkg::DATA_W-1:0]   prdata,
    output logic                              pready,
    output logic                              pslverr,
    // timer core
    input  wire logic [tmc_pkg::CNT_W-1:0]    counter_value,
    input  wire logic                         count_down,
    input  wire logic                         counter_tick,
    input  wire logic                         update_event,
    input  wire logic                         trigger_edge,
    input  wire logic                         filtered_ext_trigger,
    input  wire logic                         internal_trigger_signal,
    input  wire logic                         chan2_filtered_in_to_chan2,
    input  wire logic                         chan3_filtered_in_to_chan2,
    input  wire logic                         chan2_filtered_in_to_chan3,
    input  wire logic                         chan3_filtered_in_to_chan3,
    // channel results
    output logic                              chan2_compare_prepare,
    output logic                              chan3_compare_prepare,
    output logic                              chan2_output,
    output logic                              chan3_output,
    output logic                              chan2_input_source,
    output logic                              chan3_input_source
);
    import tmc_pkg::*;

    // -------------------------------------------------------------
    // register state
    // -------------------------------------------------------------
    logic [15:0]       mode_ctl_reg;
    logic [15:0]       chan_en_reg;
    logic [DATA_W-1:0] prdata_reg;

    logic              wr_access;
    logic              rd_setup;
    logic              addr_hit;
    logic [15:0]       mode_ctl_next;
    logic [DATA_W-1:0] rd_next;

    // per-channel views
    logic [NCHAN-1:0]       prep;
    logic [NCHAN-1:0]       chan_out;
    logic [NCHAN-1:0]       in_src;
    logic [NCHAN-1:0]       cc_enable;
    logic [NCHAN-1:0]       cc_polarity;
    logic [NCHAN-1:0]       cv_wr;
    logic [NCHAN-1:0]       own_in;
    logic [NCHAN-1:0]       other_in;
    logic [CNT_W-1:0]       cv_preload [NCHAN];
    logic [CNT_W-1:0]       cv_active  [NCHAN];

    // -------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------
    // zero wait state: every access completes in its first access cycle
    assign pready    = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign rd_setup  = psel && !penable && !pwrite;

    // address hit for the five mapped words
    always_comb
    begin
        unique case (paddr)
            OFS_MODE_CTL,
            OFS_CHAN_EN,
            OFS_CV2,
            OFS_CV3,
            OFS_STATUS: addr_hit = 1'b1;
            default:    addr_hit = 1'b0;
        endcase
    end

    // unmapped addresses answer with an error, no side effect
    assign pslverr = psel && penable && !addr_hit;

    // -------------------------------------------------------------
    // mode control register
    // -------------------------------------------------------------
    // mode select bits keep their value while the owning channel is enabled
    always_comb
    begin
        mode_ctl_next = pwdata[15:0];
        for (int c = 0; c < NCHAN; c++)
        begin
            if (cc_enable[c])
                mode_ctl_next[c*CHAN_FIELD_W + MS_LSB +: 2] =
                    mode_ctl_reg[c*CHAN_FIELD_W + MS_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_ctl_reg <= MODE_CTL_RST;
        else if (wr_access && paddr == OFS_MODE_CTL)
            mode_ctl_reg <= mode_ctl_next;
    end

    // -------------------------------------------------------------
    // enable / polarity register
    // -------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            chan_en_reg <= CHAN_EN_RST;
        else if (wr_access && paddr == OFS_CHAN_EN)
            chan_en_reg <= pwdata[15:0];
    end

    // compare value write strobes
    assign cv_wr[0] = wr_access && paddr == OFS_CV2;
    assign cv_wr[1] = wr_access && paddr == OFS_CV3;

    // -------------------------------------------------------------
    // read path
    // -------------------------------------------------------------
    // read data is captured in the setup cycle, stable in access
    always_comb
    begin
        rd_next = '0;
        unique case (paddr)
            OFS_MODE_CTL: rd_next[15:0] = mode_ctl_reg;
            OFS_CHAN_EN:  rd_next[15:0] = chan_en_reg;
            OFS_CV2:      rd_next[CNT_W-1:0] = cv_preload[0];
            OFS_CV3:      rd_next[CNT_W-1:0] = cv_preload[1];
            OFS_STATUS:
            begin
                rd_next[ST_PREP_LSB +: NCHAN] = prep;
                rd_next[ST_OUT_LSB +: NCHAN]  = chan_out;
                rd_next[ST_SRC_LSB +: NCHAN]  = in_src;
            end
            default:      rd_next = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= '0;
        else if (rd_setup)
            prdata_reg <= rd_next;
    end

    assign prdata = prdata_reg;

    // -------------------------------------------------------------
    // input routing between the two channels
    // -------------------------------------------------------------
    assign own_in[0]   = chan2_filtered_in_to_chan2;
    assign other_in[0] = chan3_filtered_in_to_chan2;
    assign own_in[1]   = chan3_filtered_in_to_chan3;
    assign other_in[1] = chan2_filtered_in_to_chan3;

    // -------------------------------------------------------------
    // per-channel compare logic (index 0 is chan2, 1 is chan3)
    // -------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NCHAN; gi++)
        begin : g_chan
            localparam int FB = gi * CHAN_FIELD_W;
            localparam int EB = EN_BIT_BASE + gi * EN_STRIDE;

            logic [1:0]    ms;
            logic          fast_en;
            logic          shadow_en;
            logic          clear_en;
            tmc_cmp_mode_t mode;
            tmc_cmp_mode_t mode_last_reg;
            logic          match;
            logic          below;
            logic          above;
            logic          pwm;
            logic          pwm_level;
            logic          cmp_level;
            logic          prep_reg;
            logic          prep_next;
            logic          fast_hit;
            logic          out_reg;

            // fields of this channel
            assign ms        = mode_ctl_reg[FB + MS_LSB +: 2];
            assign fast_en   = mode_ctl_reg[FB + FAST_BIT];
            assign shadow_en = mode_ctl_reg[FB + SHADOW_BIT];
            assign clear_en  = mode_ctl_reg[FB + CLR_BIT];
            assign mode      = tmc_cmp_mode_t'(mode_ctl_reg[FB + CTL_LSB +: 3]);
            assign cc_enable[gi]   = chan_en_reg[EB];
            assign cc_polarity[gi] = chan_en_reg[EB + POL_OFS];

            // compare value with optional shadow copy
            tmc_cv_shadow #(
                .W (CNT_W)
            ) u_cv (
                .pclk         (pclk),
                .presetn      (presetn),
                .wr_en        (cv_wr[gi]),
                .wr_data      (pwdata[CNT_W-1:0]),
                .shadow_en    (shadow_en),
                .update_event (update_event),
                .preload      (cv_preload[gi]),
                .active       (cv_active[gi])
            );

            // capture source selection
            tmc_in_mux u_mux (
                .pclk         (pclk),
                .presetn      (presetn),
                .mode_select  (ms),
                .own_in       (own_in[gi]),
                .other_in     (other_in[gi]),
                .trig_in      (internal_trigger_signal),
                .input_source (in_src[gi])
            );

            // counter against compare value
            assign match = counter_value == cv_active[gi];
            assign below = counter_value <  cv_active[gi];
            assign above = counter_value >  cv_active[gi];
            assign pwm   = mode == CMP_PWM0 || mode == CMP_PWM1;

            // fast path: a trigger edge stands in for a match
            assign fast_hit = pwm && fast_en && trigger_edge;

            // pwm shape from comparison and direction
            always_comb
            begin
                if (count_down)
                    pwm_level = !above;
                else
                    pwm_level = below;
                if (mode == CMP_PWM1)
                    pwm_level = !pwm_level;
            end

            // level a pwm channel takes at the compare point
            assign cmp_level = (mode == CMP_PWM1) ? !count_down : count_down;

            // previous control setting, to spot entry from frozen
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    mode_last_reg <= CMP_FROZEN;
                else
                    mode_last_reg <= mode;
            end

            // prepare signal next value, clear has top priority
            always_comb
            begin
                prep_next = prep_reg;
                unique case (mode)
                    CMP_FROZEN:     prep_next = prep_reg;
                    CMP_SET:
                        if (counter_tick && match)
                            prep_next = 1'b1;
                    CMP_CLEAR:
                        if (counter_tick && match)
                            prep_next = 1'b0;
                    CMP_TOGGLE:
                        if (counter_tick && match)
                            prep_next = !prep_reg;
                    CMP_FORCE_LOW:  prep_next = 1'b0;
                    CMP_FORCE_HIGH: prep_next = 1'b1;
                    CMP_PWM0,
                    CMP_PWM1:
                        if (fast_hit)
                            prep_next = cmp_level;
                        else if (counter_tick || mode_last_reg == CMP_FROZEN)
                            prep_next = pwm_level;
                endcase
                // external clear overrides every setting
                if (clear_en && filtered_ext_trigger)
                    prep_next = 1'b0;
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    prep_reg <= 1'b0;
                else
                    prep_reg <= prep_next;
            end

            // channel output: active high prepare through polarity
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    out_reg <= 1'b0;
                else if (cc_enable[gi] && tmc_ms_t'(ms) == MS_OUTPUT)
                    out_reg <= prep_reg ^ cc_polarity[gi];
                else
                    out_reg <= 1'b0;
            end

            // per-channel results out to the flat views
            assign prep[gi]     = prep_reg;
            assign chan_out[gi] = out_reg;
        end
    endgenerate

    // -------------------------------------------------------------
    // named outputs
    // -------------------------------------------------------------
    assign chan2_compare_prepare = prep[0];
    assign chan3_compare_prepare = prep[1];
    assign chan2_output          = chan_out[0];
    assign chan3_output          = chan_out[1];
    assign chan2_input_source    = in_src[0];
    assign chan3_input_source    = in_src[1];
endmodule : tmc_top
`default_nettype wire

// ==== bench/tmc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------
// prepare checker
// ----------
module tmc_chk
(
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic [tmc_pkg::ADDR_W-1:0] paddr,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [tmc_pkg::DATA_W-1:0] pwdata,
    input wire logic                       counter_tick,
    input wire logic                       trigger_edge,
    input wire logic                       filtered_ext_trigger,
    input wire logic                       chan2_compare_prepare,
    input wire logic                       chan3_compare_prepare
);
    import tmc_pkg::*;
    logic [15:0] ctl_reg;
    logic [2:0]  m2;
    logic [2:0]  m3;
    logic        kill2;
    logic        kill3;
    logic        p2;

    // mirror of mode control writes
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) ctl_reg <= MODE_CTL_RST;
        else if (psel && penable && pwrite && paddr == OFS_MODE_CTL) ctl_reg <= pwdata[15:0];

    // fields and clear condition
    assign m2    = ctl_reg[6:4];
    assign m3    = ctl_reg[14:12];
    assign kill2 = ctl_reg[7] && filtered_ext_trigger;
    assign kill3 = ctl_reg[15] && filtered_ext_trigger;
    assign p2    = chan2_compare_prepare;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // pwm settled for two cycles, nothing to react to
    sequence s_pwm_settled;
        $past(m2[2:1]) == 2'b11 && $past(m2[2:1], 2) == 2'b11;
    endsequence
    sequence s_pwm_quiet;
        m2[2:1] == 2'b11 && !counter_tick && !trigger_edge && !kill2;
    endsequence
    property p_pwm_hold; s_pwm_settled ##0 s_pwm_quiet |=> $stable(p2); endproperty
    a_pwm_hold: assert property (p_pwm_hold) else $error("pwm level moved");
    property p_kill; kill2 |=> !p2; endproperty
    a_kill: assert property (p_kill) else $error("clear not applied");
    property p_frozen; m2 == CMP_FROZEN && !kill2 |=> $stable(p2); endproperty
    a_frozen: assert property (p_frozen) else $error("frozen moved");
    property p_set; m2 == CMP_SET && !kill2 |=> !$fell(p2); endproperty
    a_set: assert property (p_set) else $error("set mode fell");
    property p_clr; m2 == CMP_CLEAR |=> !$rose(p2); endproperty
    a_clr: assert property (p_clr) else $error("clear mode rose");
    property p_tog; m2 == CMP_TOGGLE && !counter_tick && !kill2 |=> $stable(p2); endproperty
    a_tog: assert property (p_tog) else $error("toggle without tick");
    property p_lo; m2 == CMP_FORCE_LOW |=> !p2; endproperty
    a_lo: assert property (p_lo) else $error("force low failed");
    property p_hi; m2 == CMP_FORCE_HIGH && !kill2 |=> p2; endproperty
    a_hi: assert property (p_hi) else $error("force high failed");
    property p_hi3; m3 == CMP_FORCE_HIGH && !kill3 |=> chan3_compare_prepare; endproperty
    a_hi3: assert property (p_hi3) else $error("chan3 force high failed");
endmodule : tmc_chk
`default_nettype wire

// ==== bench/tmc_timer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------
// counter partner
// ----------
module tmc_timer_model
#(
    parameter int PERIOD = 9
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        run,
    input  wire logic        down,
    output logic      [15:0] counter_value,
    output logic             counter_tick,
    output logic             update_event
);
    logic wrap;

    // wrap point follows direction
    assign wrap         = down ? counter_value == 16'h0 : counter_value == 16'(PERIOD);
    assign counter_tick = run; // advances every running cycle
    assign update_event = run && wrap;

    // up or down count with reload
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) counter_value <= 16'h0;
        else if (run && wrap) counter_value <= down ? 16'(PERIOD) : 16'h0;
        else if (run) counter_value <= down ? counter_value - 16'h1 : counter_value + 16'h1;
endmodule : tmc_timer_model
`default_nettype wire

// ==== bench/timer_ch23_output_compare_mode_test.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------
// testbench
// ----------
module timer_ch23_output_compare_mode_test;
    import tmc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] counter_value;
    logic        counter_tick, update_event, run, down, trig, ext, p;
    logic [2:0]  src;
    logic        prep2, prep3, out2, out3, is2, is3;
    int          err_total, check_count;

    tmc_timer_model #(.PERIOD(9)) u_model
    (
        .pclk, .presetn, .run, .down, .counter_value, .counter_tick, .update_event
    );
    tmc_top DUT
    (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .counter_value, .count_down(down), .counter_tick, .update_event,
        .trigger_edge(trig), .filtered_ext_trigger(ext), .internal_trigger_signal(src[2]),
        .chan2_filtered_in_to_chan2(src[0]), .chan3_filtered_in_to_chan2(src[1]),
        .chan2_filtered_in_to_chan3(src[1]), .chan3_filtered_in_to_chan3(src[0]),
        .chan2_compare_prepare(prep2), .chan3_compare_prepare(prep3),
        .chan2_output(out2), .chan3_output(out3),
        .chan2_input_source(is2), .chan3_input_source(is3)
    );

    // clock
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // hang guard
    initial
    begin
        repeat (5000) @(posedge pclk);
        err_total++;
        print_verdict();
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic at_cnt(input logic [15:0] v);
        do @(posedge pclk); while (counter_value !== v);
        #1;
    endtask : at_cnt

    task automatic mode(input logic [31:0] d);
        at_cnt(16'h0);
        apb(1'b1, OFS_MODE_CTL, d);
    endtask : mode

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, run, down, trig, ext} = 8'h00;
        {paddr, pwdata, src} = 43'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_MODE_CTL, 32'h0);
        chk(rd, 32'(MODE_CTL_RST));
        apb(1'b0, 8'h14, 32'h0);
        chk(er, 32'h1);
        chk(rd, 32'h0);
        $display("test reset done");
        for (int ms = 0; ms < 4; ms++)
        begin
            apb(1'b1, OFS_MODE_CTL, 32'(ms * 257));
            for (int k = 0; k < 3; k++)
            begin
                @(posedge pclk);
                src <= 3'(1 << k);
                repeat (2) @(posedge pclk);
                #1;
                chk(is2, 32'(ms != 0 && k + 1 == ms));
                chk(is3, 32'(ms != 0 && k + 1 == ms));
            end
        end
        apb(1'b1, OFS_CHAN_EN, 32'h100);
        apb(1'b1, OFS_MODE_CTL, 32'h0);
        apb(1'b0, OFS_MODE_CTL, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, OFS_CHAN_EN, 32'h0);
        apb(1'b1, OFS_MODE_CTL, 32'h0);
        $display("test mode select done");
        apb(1'b1, OFS_CV2, 32'h5);
        @(posedge pclk);
        run <= 1'b1;
        mode(32'h10);
        at_cnt(16'h6);
        chk(prep2, 32'h1);
        mode(32'h20);
        at_cnt(16'h6);
        chk(prep2, 32'h0);
        mode(32'h30);
        at_cnt(16'h6);
        p = prep2;
        chk(p, 32'h1);
        at_cnt(16'h6);
        chk(prep2, 32'h0);
        at_cnt(16'h6);
        chk(prep2, 32'h1);
        mode(32'h0);
        at_cnt(16'h6);
        chk(prep2, 32'h1);
        mode(32'h40);
        at_cnt(16'h6);
        chk(prep2, 32'h0);
        mode(32'hd0);
        at_cnt(16'h6);
        chk(prep2, 32'h1);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge pclk);
            ext <= (i == 0);
            repeat (2) @(posedge pclk);
            #1;
            chk(prep2, 32'(i));
            apb(1'b1, OFS_CHAN_EN, 32'h100 + 32'((1 - i) * 512));
            repeat (2) @(posedge pclk);
            #1;
            chk(out2, 32'h1);
        end
        mode(32'h5000);
        at_cnt(16'h2);
        chk(prep3, 32'h1);
        apb(1'b1, OFS_CHAN_EN, 32'h1000);
        at_cnt(16'h2);
        chk(out3, 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'hb);
        $display("test compare done");
        for (int m = 0; m < 4; m++)
        begin
            @(posedge pclk);
            down <= m[0];
            mode(32'h60 + 32'(m / 2 * 16));
            at_cnt(16'h2);
            chk(prep2, 32'(m < 2));
            at_cnt(16'h7);
            chk(prep2, 32'(m >= 2));
        end
        @(posedge pclk);
        down <= 1'b0;
        mode(32'h68);
        at_cnt(16'h0);
        apb(1'b1, OFS_CV2, 32'h8);
        at_cnt(16'h7);
        chk(prep2, 32'h0);
        at_cnt(16'h7);
        chk(prep2, 32'h1);
        apb(1'b0, OFS_CV2, 32'h0);
        chk(rd, 32'h8);
        mode(32'h64);
        @(posedge pclk);
        run <= 1'b0;
        @(posedge pclk);
        trig <= 1'b1;
        #1;
        chk(prep2, 32'h1);
        @(posedge pclk);
        trig <= 1'b0;
        @(posedge pclk);
        #1;
        chk(prep2, 32'h0);
        $display("test pwm done");
        print_verdict();
    end
endmodule : timer_ch23_output_compare_mode_test

bind tmc_top tmc_chk u_chk
(
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .counter_tick, .trigger_edge,
    .filtered_ext_trigger, .chan2_compare_prepare, .chan3_compare_prepare
);
`default_nettype wire
